// >>> common/cmx_regs.vh
`ifndef CMX_REGS_VH
`define CMX_REGS_VH

// quarter-cycle phases of one instruction cycle
`define CMX_Q1            2'h0
`define CMX_Q2            2'h1
`define CMX_Q3            2'h2
`define CMX_Q4            2'h3

// opcode patterns, compared on the upper bits of the word
`define CMX_OPC_CMP       7'h30
`define CMX_OPC_MOV1      9'h1D7
`define CMX_OPC_MOV2      4'hF
`define CMX_OPC_PUSH      8'hEA

// quick bank split: low offsets map to page 0, the rest to the top page
`define CMX_QUICK_SPLIT   8'h60
`define CMX_QUICK_HI_PAGE 4'hF

// indirect addressing register addresses, three groups of five
`define CMX_IND0_BASE     12'hFEB
`define CMX_IND1_BASE     12'hFE3
`define CMX_IND2_BASE     12'hFDB
`define CMX_IND_SPAN      12'h004

// reset values
`define CMX_PTR_RST       12'h000
`define CMX_BYTE_RST      8'h00

`endif

// >>> rtl/cmx_data_mem.v
`timescale 1ns/1ps
// byte-wide data space; read data is registered, so it lags the address by one edge
module cmx_data_mem #(
  parameter AW = 12,
  parameter DW = 8
) (
  input  wire          core_clk_i,
  input  wire [AW-1:0] addr_i,
  input  wire          we_i,
  input  wire [DW-1:0] wdata_i,
  output reg  [DW-1:0] rdata_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array; contents are undefined until written
  always @(posedge core_clk_i)
  begin
    if (we_i)
      mem[addr_i] <= wdata_i;
    rdata_o <= mem[addr_i];
  end

endmodule // cmx_data_mem

// >>> rtl/cmx_exec.v
`timescale 1ns/1ps
`include "cmx_regs.vh"

// Operation
// - compare_skip_less: unsigned f minus accumulator, skip if less
// - bank bit zero: operand from quick bank
// - bank bit one: bank_select_value picks bank
// - one cycle, two on skip, three over two-word
// - indexed_move: pointer plus 7-bit offsets, copy byte
// - indirect register as source reads zero
// - literal_push stores literal at indirect_pointer_two
// - then indirect_pointer_two decrements by one
// - literal_push completes in one cycle, four quarters
module cmx_exec #(
  parameter AW = 12,
  parameter DW = 8
) (
  input  wire          core_clk_i,
  input  wire          reset_n_i,
  input  wire          instr_valid_i,
  input  wire [15:0]   instr_word_i,
  input  wire          next_two_word_i,
  input  wire [DW-1:0] accumulator_i,
  input  wire [3:0]    bank_select_value_i,
  input  wire          ptr_load_i,
  input  wire [AW-1:0] ptr_load_value_i,
  input  wire          load_we_i,
  input  wire [AW-1:0] load_addr_i,
  input  wire [DW-1:0] load_data_i,
  output reg  [1:0]    quarter_o,
  output reg           cycle_end_o,
  output reg           discard_o,
  output reg           cmp_less_o,
  output reg  [AW-1:0] indirect_pointer_two_o,
  output reg           wr_valid_o,
  output reg  [AW-1:0] wr_addr_o,
  output reg  [DW-1:0] wr_data_o
);

  // kinds of work held for the current instruction cycle
  localparam K_IDLE = 3'h0;
  localparam K_CMP  = 3'h1;
  localparam K_MOV1 = 3'h2;
  localparam K_MOV2 = 3'h3;
  localparam K_PUSH = 3'h4;

  reg [1:0]    quarter;
  reg [2:0]    kind;
  reg [15:0]   op;
  reg [1:0]    skip_left;
  reg          mov_pending;
  reg [DW-1:0] mov_data;
  reg [AW-1:0] ptr;
  reg [AW-1:0] oper_addr;
  reg          dest_blocked;

  wire [DW-1:0] mem_rdata;
  reg  [AW-1:0] mem_addr;
  reg           mem_we;
  reg  [DW-1:0] mem_wdata;
  reg  [AW-1:0] next_oper_addr;

  // pointer plus unsigned 7-bit offset, wraps inside the data space
  function [AW-1:0] ptr_plus;
    input [AW-1:0] base;
    input [6:0]    ofs;
    begin
      ptr_plus = base + {{(AW-7){1'b0}}, ofs};
    end
  endfunction

  // true for any of the fifteen indirect addressing register addresses
  function is_indirect;
    input [AW-1:0] a;
    begin
      is_indirect = ((a >= `CMX_IND0_BASE) && (a <= `CMX_IND0_BASE + `CMX_IND_SPAN))
                 || ((a >= `CMX_IND1_BASE) && (a <= `CMX_IND1_BASE + `CMX_IND_SPAN))
                 || ((a >= `CMX_IND2_BASE) && (a <= `CMX_IND2_BASE + `CMX_IND_SPAN));
    end
  endfunction

  // quick bank or banked space for the compare operand
  function [AW-1:0] file_addr;
    input       bank_mode;
    input [3:0] bank_sel;
    input [7:0] f;
    begin
      if (bank_mode)
        file_addr = {bank_sel, f};
      else if (f < `CMX_QUICK_SPLIT)
        file_addr = {4'h0, f};
      else
        file_addr = {`CMX_QUICK_HI_PAGE, f};
    end
  endfunction

  // operand address is formed ahead of the Q2 edge; the memory read data is
  // registered, so issuing the read on that edge is what makes it ready at Q3
  always @*
  begin
    if (kind == K_CMP)
      next_oper_addr = file_addr(op[8], bank_select_value_i, op[7:0]);
    else
      next_oper_addr = ptr_plus(ptr, op[6:0]);
  end

  cmx_data_mem #(
    .AW (AW),
    .DW (DW)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .addr_i     (mem_addr),
    .we_i       (mem_we),
    .wdata_i    (mem_wdata),
    .rdata_o    (mem_rdata)
  );

  // memory port: execution writes in Q4, reads are issued in Q2; the load port
  // only reaches memory while no instruction uses it, so loads may be dropped
  always @*
  begin
    mem_addr  = load_addr_i;
    mem_we    = load_we_i && (kind == K_IDLE);
    mem_wdata = load_data_i;
    if (kind == K_PUSH)
    begin
      mem_addr  = ptr;
      mem_we    = (quarter == `CMX_Q4);
      mem_wdata = op[7:0];
    end
    else if (kind == K_CMP || kind == K_MOV1)
    begin
      mem_addr = (quarter == `CMX_Q2) ? next_oper_addr : oper_addr;
      mem_we   = 1'b0;
    end
    else if (kind == K_MOV2)
    begin
      mem_addr  = oper_addr;
      mem_we    = (quarter == `CMX_Q4) && !dest_blocked;
      mem_wdata = mov_data;
    end
  end

  // four-quarter sequencer and per-instruction execution
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      quarter      <= `CMX_Q1;
      kind         <= K_IDLE;
      op           <= 16'h0000;
      skip_left    <= 2'h0;
      mov_pending  <= 1'b0;
      mov_data     <= `CMX_BYTE_RST;
      ptr          <= `CMX_PTR_RST;
      oper_addr    <= `CMX_PTR_RST;
      dest_blocked <= 1'b0;
      cycle_end_o  <= 1'b0;
      discard_o    <= 1'b0;
      cmp_less_o   <= 1'b0;
      wr_valid_o   <= 1'b0;
      wr_addr_o    <= `CMX_PTR_RST;
      wr_data_o    <= `CMX_BYTE_RST;
    end
    else
    begin
      quarter     <= quarter + 2'h1;
      cycle_end_o <= (quarter == `CMX_Q4);
      wr_valid_o  <= 1'b0;
      case (quarter)
        `CMX_Q1:
        begin
          // decode; a discarded cycle runs as an idle operation
          discard_o <= (skip_left != 2'h0);
          op        <= instr_word_i;
          if (skip_left != 2'h0)
            kind <= K_IDLE;
          else if (mov_pending)
            kind <= (instr_word_i[15:12] == `CMX_OPC_MOV2) ? K_MOV2 : K_IDLE;
          else if (!instr_valid_i)
            kind <= K_IDLE;
          else if (instr_word_i[15:9] == `CMX_OPC_CMP)
            kind <= K_CMP;
          else if (instr_word_i[15:7] == `CMX_OPC_MOV1)
            kind <= K_MOV1;
          else if (instr_word_i[15:8] == `CMX_OPC_PUSH)
            kind <= K_PUSH;
          else
            kind <= K_IDLE;
        end
        `CMX_Q2:
        begin
          // hold the operand address; the memory read is launched on this edge
          if (kind == K_CMP || kind == K_MOV1 || kind == K_MOV2)
            oper_addr <= next_oper_addr;
        end
        `CMX_Q3:
        begin
          if (kind == K_CMP)
          begin
            // unsigned subtract, borrow means operand is smaller
            cmp_less_o <= (mem_rdata < accumulator_i);
            if (mem_rdata < accumulator_i)
              skip_left <= next_two_word_i ? 2'h2 : 2'h1;
          end
          else if (kind == K_MOV1)
            mov_data <= is_indirect(oper_addr) ? `CMX_BYTE_RST : mem_rdata;
          else if (kind == K_MOV2)
            dest_blocked <= is_indirect(oper_addr);
        end
        default:
        begin
          // Q4: write back and close the cycle
          if (skip_left != 2'h0 && kind == K_IDLE)
            skip_left <= skip_left - 2'h1;
          mov_pending <= (kind == K_MOV1);
          if (kind == K_PUSH)
          begin
            wr_valid_o <= 1'b1;
            wr_addr_o  <= ptr;
            wr_data_o  <= op[7:0];
            ptr        <= ptr - {{(AW-1){1'b0}}, 1'b1};
          end
          else if (kind == K_MOV2 && !dest_blocked)
          begin
            // destination is trusted not to be pc-low or stack-top bytes
            wr_valid_o <= 1'b1;
            wr_addr_o  <= oper_addr;
            wr_data_o  <= mov_data;
          end
          else if (ptr_load_i && kind == K_IDLE)
            ptr <= ptr_load_value_i;
        end
      endcase
    end
  end

  // visible copies of sequencer state
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      quarter_o              <= `CMX_Q1;
      indirect_pointer_two_o <= `CMX_PTR_RST;
    end
    else
    begin
      quarter_o              <= quarter;
      indirect_pointer_two_o <= ptr;
    end
  end

endmodule // cmx_exec

// >>> verification/cmx_exec_assertions.sv
`timescale 1ns/1ps
// watches the execution outputs of cmx_exec
module cmx_exec_chk #(
  parameter AW = 12
) (
  input wire          core_clk_i,
  input wire          reset_n_i,
  input wire [1:0]    quarter_o,
  input wire          cycle_end_o,
  input wire          discard_o,
  input wire          cmp_less_o,
  input wire [AW-1:0] indirect_pointer_two_o,
  input wire          wr_valid_o,
  input wire [AW-1:0] wr_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // an instruction cycle is four clocks; a skipped one stays idle all four
  sequence s_gap;
    !cycle_end_o [*3] ##1 cycle_end_o;
  endsequence
  sequence s_skip;
    discard_o [*4];
  endsequence
  property p_end_gap; cycle_end_o |=> s_gap; endproperty
  property p_wrap; quarter_o == 2'h3 |=> quarter_o == 2'h0; endproperty
  property p_wr_pulse; wr_valid_o |-> cycle_end_o ##1 !wr_valid_o; endproperty
  property p_skip_min; $rose(discard_o) |-> s_skip; endproperty
  property p_skip_max; $rose(discard_o) |-> ##[4:8] !discard_o; endproperty
  property p_skip_cause; $rose(discard_o) |-> cmp_less_o; endproperty
  property p_skip_quiet; discard_o |-> !wr_valid_o; endproperty
  // a pointer move right after a write must be the push decrement
  property p_ptr_dec;
    $changed(indirect_pointer_two_o) && $past(wr_valid_o) |-> indirect_pointer_two_o == $past(wr_addr_o) - 1'b1;
  endproperty
  property p_push_addr;
    $changed(indirect_pointer_two_o) && $past(wr_valid_o) |-> $past(wr_addr_o) == $past(indirect_pointer_two_o);
  endproperty
  a_end_gap: assert property (p_end_gap) else $error("cycle end spacing wrong");
  a_wrap: assert property (p_wrap) else $error("quarter did not wrap");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse misplaced");
  a_skip_min: assert property (p_skip_min) else $error("skip shorter than a cycle");
  a_skip_max: assert property (p_skip_max) else $error("skip longer than two cycles");
  a_skip_cause: assert property (p_skip_cause) else $error("skip without less result");
  a_skip_quiet: assert property (p_skip_quiet) else $error("write during skip");
  a_ptr_dec: assert property (p_ptr_dec) else $error("pointer not decremented");
  a_push_addr: assert property (p_push_addr) else $error("push address not pointer");
endmodule // cmx_exec_chk

bind cmx_exec cmx_exec_chk #(.AW(AW)) u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .quarter_o(quarter_o),
  .cycle_end_o(cycle_end_o), .discard_o(discard_o), .cmp_less_o(cmp_less_o), .wr_addr_o(wr_addr_o),
  .indirect_pointer_two_o(indirect_pointer_two_o), .wr_valid_o(wr_valid_o));

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         v = 1'b0, tw = 1'b0, pl = 1'b0, lw = 1'b0;
  reg  [15:0] w = 16'h0000, wn, dn;
  reg  [7:0]  acc = 8'h00, ld = 8'h00, md;
  reg  [3:0]  bs = 4'h0;
  reg  [11:0] pv = 12'h000, la = 12'h000, ma;
  wire [1:0]  q;
  wire        ce, dc, cl, wv;
  wire [11:0] ptr, wa;
  wire [7:0]  wd;
  integer     fail_count = 0, comparisons = 0;
  cmx_exec DUT (.core_clk_i(clk), .reset_n_i(rst_n), .instr_valid_i(v), .instr_word_i(w), .next_two_word_i(tw),
    .accumulator_i(acc), .bank_select_value_i(bs), .ptr_load_i(pl), .ptr_load_value_i(pv), .load_we_i(lw),
    .load_addr_i(la), .load_data_i(ld), .quarter_o(q), .cycle_end_o(ce), .discard_o(dc), .cmp_less_o(cl),
    .indirect_pointer_two_o(ptr), .wr_valid_o(wv), .wr_addr_o(wa), .wr_data_o(wd));
  always #12.5 clk = ~clk;
  // tally writes and skipped clocks; only the last write is kept
  always @(posedge clk)
  begin
    if (wv === 1'b1)
    begin
      wn <= wn + 1'b1;
      ma <= wa;
      md <= wd;
    end
    if (dc === 1'b1) dn <= dn + 1'b1;
  end
  task chk(input [15:0] s, input [15:0] e);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  end
  endtask
  // one four-clock instruction cycle, inputs moved 1 ns after the edge
  task cy(input [15:0] word, input val);
  begin
    w = word;
    v = val;
    repeat (4) @(posedge clk);
    #1;
  end
  endtask
  // backdoor byte and pointer loads need an idle cycle
  task ld_(input [11:0] a, input [7:0] d);
  begin
    la = a; ld = d; lw = 1'b1; cy(16'h0000, 1'b0); lw = 1'b0;
  end
  endtask
  task sp(input [11:0] p);
  begin
    pv = p; pl = 1'b1; cy(16'h0000, 1'b0); pl = 1'b0; wn = 16'h0000; dn = 16'h0000;
  end
  endtask
  task t_push;
  begin
    sp(12'h1EC);
    cy(16'hEA08, 1'b1); cy(16'hEA5A, 1'b1); cy(16'h0000, 1'b0); cy(16'h0000, 1'b0);
    chk(wn, 16'h0002);
    chk(ma, 12'h1EB);
    chk(md, 8'h5A);
    chk(ptr, 12'h1EA);
    chk(ce, 1'b1);
    chk(q, 2'h3);
  end
  endtask
  task t_move;
  begin
    ld_(12'h085, 8'h33); ld_(12'hFDB, 8'h5A); sp(12'h080);
    cy(16'hEB85, 1'b1); cy(16'hF006, 1'b1); cy(16'h0000, 1'b0); cy(16'h0000, 1'b0);
    chk(wn, 16'h0001);
    chk(ma, 12'h086);
    chk(md, 8'h33);
    sp(12'hFD0);
    cy(16'hEB8B, 1'b1); cy(16'hF001, 1'b1); cy(16'hEB81, 1'b1); cy(16'hF013, 1'b1); cy(16'h0000, 1'b0); cy(16'h0000, 1'b0);
    chk(wn, 16'h0001);
    chk(ma, 12'hFD1);
    chk(md, 8'h00);
  end
  endtask
  // quick bank byte is less, banked byte is not; a push in the skip is dropped
  task t_cmp;
  begin
    ld_(12'h010, 8'h05); ld_(12'h310, 8'h20); sp(12'h200);
    acc = 8'h09; bs = 4'h3;
    cy(16'h6010, 1'b1); cy(16'hEA77, 1'b1); cy(16'h0000, 1'b0); cy(16'h0000, 1'b0);
    chk(cl, 1'b1);
    chk(dn, 16'h0004);
    chk(wn, 16'h0000);
    cy(16'h6110, 1'b1); cy(16'h0000, 1'b0);
    chk(cl, 1'b0);
    acc = 8'hF0; tw = 1'b1; dn = 16'h0000;
    cy(16'h6110, 1'b1); tw = 1'b0; cy(16'hEA77, 1'b1); cy(16'hF000, 1'b1); cy(16'h0000, 1'b0); cy(16'h0000, 1'b0);
    chk(cl, 1'b1);
    chk(dn, 16'h0008);
    chk(wn, 16'h0000);
  end
  endtask
  task end_sim;
  begin
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // the whole run is about 150 clocks; this bound is generous
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_push;
    t_move;
    t_cmp;
    end_sim;
  end
endmodule // testbench
